// *** shared/sbc_reset_consts.vh ***
`ifndef SBC_RESET_CONSTS_VH
`define SBC_RESET_CONSTS_VH

// Register selects on the write port
`define SEL_W            3
`define SEL_MODE         3'h0
`define SEL_INT_EN       3'h1
`define SEL_INT          3'h2
`define SEL_SYSCFG       3'h3
`define SEL_PHY          3'h4
`define SEL_SPECIAL      3'h5
`define SEL_GP0          3'h6
`define SEL_GP1          3'h7

// Mode register
`define MODE_DBG_BIT     0

// Diagnosis word layout and power-on value
`define DIAG_W           12
`define DIAG_GSD_BIT     0
`define DIAG_CANF_LSB    1
`define DIAG_LINF_LSB    5
`define DIAG_SUP_LSB     7
`define DIAG_CANM_LSB    10
`define DIAG_POR         12'h380

// System configuration layout
`define CFG_W            10
`define CFG_KEEP_LSB     0
`define CFG_KEEP_W       4
`define CFG_KEEP_POR     4'h4
`define CFG_RST_LSB      4
`define CFG_RST_W        2
`define CFG_RST_POR      2'h1
`define CFG_SUP3_LSB     6
`define CFG_SUP3_W       2
`define CFG_SUP3_POR     2'h0
`define CFG_LOAD_LSB     8
`define CFG_LOAD_W       2
`define CFG_LOAD_POR     2'h0

// Physical layer control layout
`define PHY_W            8
`define PHY_POR          8'h42

// Special mode register layout
`define SPC_W            3
`define SPC_ENTRY_BIT    0
`define SPC_ERR_BIT      1
`define SPC_LIMP_BIT     2

// Interrupt events
`define EVT_W            4
`define EVT_WD_OVF       0
`define EVT_WD_WIN       1
`define EVT_INT_TO       2
`define EVT_SU_TO        3

// Reset source codes
`define RSRC_W           4
`define RSRC_NONE        4'h0
`define RSRC_WD_OVF      4'h1
`define RSRC_WD_WIN      4'h2
`define RSRC_INT_TO      4'h3
`define RSRC_SU_TO       4'h4

// General purpose words
`define GP_W             12
`define GP0_MARK_BIT     11
`define GP0_VER_LSB      7
`define GP0_VER_W        4
`define GP0_TYPE_W       7

// Timing
`define CLK_HZ           40000000
`define STARTUP_WIN_MS   256
`define MAIN_UV_MS       256
`define TIMER_W          24

`endif

// *** verilog/reset_class_field.v ***
`include "sbc_reset_consts.vh"

// Field that reloads its power-on value on selected reset classes
module reset_class_field #(
  parameter         W        = 1,
  parameter [W-1:0] POR_VAL  = {W{1'b0}},
  parameter         SU_LOAD  = 0,
  parameter         EXT_LOAD = 0,
  parameter         RS_LOAD  = 0
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         su,
  input  wire         ext,
  input  wire         rs,
  input  wire         force_por,
  input  wire         wr,
  input  wire [W-1:0] wr_val,
  output reg  [W-1:0] q
);

  wire reload;

  assign reload = (su && (SU_LOAD != 0)) || (ext && (EXT_LOAD != 0)) ||
                  (rs && (RS_LOAD != 0)) || force_por;

  always @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      q <= POR_VAL;
    else if (reload)
      q <= POR_VAL;
    else if (wr)
      q <= wr_val;
  end

endmodule // reset_class_field

// *** verilog/sbc_reset_state.v ***
`include "sbc_reset_consts.vh"

// Behaviour
// - Diagnosis fixed at power-on, live after the first non power-on reset
// - Interrupt enables cleared only at power-on
// - Pending interrupts cleared on every reset
// - Reset length/threshold reload at power-on, restart
// - Third supply off at power-on, external reset
// - Load switch floats on external reset, restart or undervoltage
// - Physical layer defaults at power-on only
// - Special mode bits cleared only at power-on
// - General word bit 11 marks identity
// - Identity codes loaded at power-on only
// - General word one cleared at power-on only
// - Debug turns watchdog faults into interrupts
// - Debug still records source and flags
// - Debug disables interrupt, init, reset monitors
// - Debug blocks fail-safe except long undervoltage
// - Software entry once, early, before other writes
// - Test pin high at power-up enters debug
// - Mode write with flag clear leaves debug
// - No re-entry until next power-on
// - Low-power watchdog unaffected by debug
// - Bit 11 sticks once general word written
// - External low on reset pin means external reset
module sbc_reset_state #(
  parameter STARTUP_CYC = `STARTUP_WIN_MS * (`CLK_HZ / 1000),
  parameter MAIN_UV_CYC = `MAIN_UV_MS * (`CLK_HZ / 1000),
  parameter [`GP0_VER_W-1:0]  VERSION_CODE = 4'h5,   // Arbitrary value
  parameter [`GP0_TYPE_W-1:0] TYPE_CODE    = 7'h2A   // Arbitrary value
) (
  input  wire                CLK,
  input  wire                RST_N,
  input  wire                STARTUP_RST,
  input  wire                EXT_RST,
  input  wire                RESTART_RST,
  input  wire                RESET_OUT_IN,
  input  wire                RESET_OUT_DRIVE,
  input  wire                WR_STB,
  input  wire [`SEL_W-1:0]   WR_SEL,
  input  wire [`GP_W-1:0]    WR_DATA,
  input  wire                TEST_PIN_HIGH,
  input  wire                LOW_POWER_MODE,
  input  wire                MAIN_UV,
  input  wire                FAILSAFE_REQ,
  input  wire                WD_OVERFLOW,
  input  wire                WD_WINDOW_MISS,
  input  wire                INT_TIMEOUT,
  input  wire                STARTUP_TIMEOUT,
  input  wire                GND_SHIFT_LIVE,
  input  wire [3:0]          CAN_FAIL_LIVE,
  input  wire [1:0]          LIN_FAIL_LIVE,
  input  wire [2:0]          SUPPLY_DIAG_LIVE,
  input  wire [1:0]          CAN_MODE_LIVE,
  output reg  [`DIAG_W-1:0]  DIAG_WORD,
  output wire [`CFG_W-1:0]   SYSCFG_FB,
  output wire [`PHY_W-1:0]   PHY_FB,
  output wire [`EVT_W-1:0]   INT_EN_FB,
  output reg  [`EVT_W-1:0]   INT_FLAGS,
  output wire [`SPC_W-1:0]   SPECIAL_FB,
  output wire [`GP_W-1:0]    GP0_FB,
  output wire [`GP_W-1:0]    GP1_FB,
  output reg                 DEBUG_ACTIVE,
  output reg                 RESET_REQ,
  output reg  [`RSRC_W-1:0]  RESET_SOURCE,
  output reg                 INT_REQ,
  output wire                INT_MON_EN,
  output wire                WD_INIT_MON_EN,
  output wire                RST_MON_EN,
  output wire                FAILSAFE_GO
);

  // Counts are cut to the timer width on purpose
  localparam [31:0]         startup_full = STARTUP_CYC;
  localparam [31:0]         uv_full      = MAIN_UV_CYC;
  localparam [`TIMER_W-1:0] win_lim      = startup_full[`TIMER_W-1:0];
  localparam [`TIMER_W-1:0] uv_lim       = uv_full[`TIMER_W-1:0];

  reg                 pin_prev;
  wire                pin_ext;
  wire                ext_cls;
  wire                su_cls;
  wire                rs_cls;
  wire                any_rst;
  reg                 diag_live;
  reg                 gp0_mark;
  reg  [`GP_W-2:0]    gp0_body;
  reg                 entry_bit;
  reg                 entry_open;
  reg                 strap_done;
  reg  [`TIMER_W-1:0] win_cnt;
  reg  [`TIMER_W-1:0] uv_cnt;
  wire                uv_long;
  wire [`EVT_W-1:0]   evt;
  wire                fault;
  wire                suppress;
  wire                wr_int;
  wire                wr_mode;
  wire                wr_special;
  wire                wr_gp0;
  reg  [`EVT_W-1:0]   next_flags;
  reg  [`RSRC_W-1:0]  next_source;
  wire [`SPC_W-2:0]   special_keep;

  // Reset classes; an external low on the reset pin is an external reset
  assign pin_ext = pin_prev && !RESET_OUT_IN && !RESET_OUT_DRIVE;
  assign ext_cls = (EXT_RST || pin_ext) && !RESTART_RST;
  assign rs_cls  = RESTART_RST;
  assign su_cls  = (STARTUP_RST || ext_cls) && !rs_cls;
  assign any_rst = su_cls || rs_cls;

  assign wr_int     = WR_STB && (WR_SEL == `SEL_INT);
  assign wr_mode    = WR_STB && (WR_SEL == `SEL_MODE);
  assign wr_special = WR_STB && (WR_SEL == `SEL_SPECIAL);
  assign wr_gp0     = WR_STB && (WR_SEL == `SEL_GP0);

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
      pin_prev <= 1'b1;
    else
      pin_prev <= RESET_OUT_IN;
  end

  // Diagnosis: fixed pattern until a non power-on reset, then live
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      diag_live <= 1'b0;
      DIAG_WORD <= `DIAG_POR;
    end
    else
    begin
      if (any_rst)
        diag_live <= 1'b1;
      if (diag_live || any_rst)
        DIAG_WORD <= {CAN_MODE_LIVE, SUPPLY_DIAG_LIVE, LIN_FAIL_LIVE,
                      CAN_FAIL_LIVE, GND_SHIFT_LIVE};
    end
  end

  // System configuration fields, grouped by reset behaviour
  reset_class_field #(
    .W        (`CFG_KEEP_W),
    .POR_VAL  (`CFG_KEEP_POR)
  ) u_cfg_keep (
    .clk       (CLK),
    .rst_n     (RST_N),
    .su        (su_cls),
    .ext       (ext_cls),
    .rs        (rs_cls),
    .force_por (1'b0),
    .wr        (WR_STB && (WR_SEL == `SEL_SYSCFG)),
    .wr_val    (WR_DATA[`CFG_KEEP_LSB +: `CFG_KEEP_W]),
    .q         (SYSCFG_FB[`CFG_KEEP_LSB +: `CFG_KEEP_W])
  );

  reset_class_field #(
    .W        (`CFG_RST_W),
    .POR_VAL  (`CFG_RST_POR),
    .RS_LOAD  (1)
  ) u_cfg_rst (
    .clk       (CLK),
    .rst_n     (RST_N),
    .su        (su_cls),
    .ext       (ext_cls),
    .rs        (rs_cls),
    .force_por (1'b0),
    .wr        (WR_STB && (WR_SEL == `SEL_SYSCFG)),
    .wr_val    (WR_DATA[`CFG_RST_LSB +: `CFG_RST_W]),
    .q         (SYSCFG_FB[`CFG_RST_LSB +: `CFG_RST_W])
  );

  reset_class_field #(
    .W        (`CFG_SUP3_W),
    .POR_VAL  (`CFG_SUP3_POR),
    .EXT_LOAD (1)
  ) u_cfg_sup3 (
    .clk       (CLK),
    .rst_n     (RST_N),
    .su        (su_cls),
    .ext       (ext_cls),
    .rs        (rs_cls),
    .force_por (1'b0),
    .wr        (WR_STB && (WR_SEL == `SEL_SYSCFG)),
    .wr_val    (WR_DATA[`CFG_SUP3_LSB +: `CFG_SUP3_W]),
    .q         (SYSCFG_FB[`CFG_SUP3_LSB +: `CFG_SUP3_W])
  );

  reset_class_field #(
    .W        (`CFG_LOAD_W),
    .POR_VAL  (`CFG_LOAD_POR),
    .EXT_LOAD (1),
    .RS_LOAD  (1)
  ) u_cfg_load (
    .clk       (CLK),
    .rst_n     (RST_N),
    .su        (su_cls),
    .ext       (ext_cls),
    .rs        (rs_cls),
    .force_por (MAIN_UV),
    .wr        (WR_STB && (WR_SEL == `SEL_SYSCFG)),
    .wr_val    (WR_DATA[`CFG_LOAD_LSB +: `CFG_LOAD_W]),
    .q         (SYSCFG_FB[`CFG_LOAD_LSB +: `CFG_LOAD_W])
  );

  reset_class_field #(
    .W        (`PHY_W),
    .POR_VAL  (`PHY_POR)
  ) u_phy (
    .clk       (CLK),
    .rst_n     (RST_N),
    .su        (su_cls),
    .ext       (ext_cls),
    .rs        (rs_cls),
    .force_por (1'b0),
    .wr        (WR_STB && (WR_SEL == `SEL_PHY)),
    .wr_val    (WR_DATA[`PHY_W-1:0]),
    .q         (PHY_FB)
  );

  reset_class_field #(
    .W        (`EVT_W)
  ) u_int_en (
    .clk       (CLK),
    .rst_n     (RST_N),
    .su        (su_cls),
    .ext       (ext_cls),
    .rs        (rs_cls),
    .force_por (1'b0),
    .wr        (WR_STB && (WR_SEL == `SEL_INT_EN)),
    .wr_val    (WR_DATA[`EVT_W-1:0]),
    .q         (INT_EN_FB)
  );

  reset_class_field #(
    .W        (`SPC_W-1)
  ) u_special (
    .clk       (CLK),
    .rst_n     (RST_N),
    .su        (su_cls),
    .ext       (ext_cls),
    .rs        (rs_cls),
    .force_por (1'b0),
    .wr        (wr_special),
    .wr_val    (WR_DATA[`SPC_LIMP_BIT:`SPC_ERR_BIT]),
    .q         (special_keep)
  );

  reset_class_field #(
    .W        (`GP_W)
  ) u_gp1 (
    .clk       (CLK),
    .rst_n     (RST_N),
    .su        (su_cls),
    .ext       (ext_cls),
    .rs        (rs_cls),
    .force_por (1'b0),
    .wr        (WR_STB && (WR_SEL == `SEL_GP1)),
    .wr_val    (WR_DATA),
    .q         (GP1_FB)
  );

  assign SPECIAL_FB = {special_keep, entry_bit};

  // General word zero: identity at power-on, bit 11 sticky afterwards
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      gp0_mark <= 1'b0;
      gp0_body <= {VERSION_CODE, TYPE_CODE};
    end
    else
    begin
      if (any_rst || wr_gp0)
        gp0_mark <= 1'b1;
      if (wr_gp0)
        gp0_body <= WR_DATA[`GP_W-2:0];
    end
  end

  assign GP0_FB = {gp0_mark, gp0_body};

  // Start-up window and long undervoltage timers
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      win_cnt <= {`TIMER_W{1'b0}};
      uv_cnt  <= {`TIMER_W{1'b0}};
    end
    else
    begin
      if (win_cnt != win_lim)
        win_cnt <= win_cnt + 1'b1;
      if (!MAIN_UV)
        uv_cnt <= {`TIMER_W{1'b0}};
      else if (uv_cnt != uv_lim)
        uv_cnt <= uv_cnt + 1'b1;
    end
  end

  assign uv_long = (uv_cnt == uv_lim);

  // Debug mode entry, exit and one-shot permission
  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      DEBUG_ACTIVE <= 1'b0;
      entry_bit    <= 1'b0;
      entry_open   <= 1'b1;
      strap_done   <= 1'b0;
    end
    else
    begin
      strap_done <= 1'b1;
      if (!strap_done && TEST_PIN_HIGH)
        DEBUG_ACTIVE <= 1'b1;
      else if (wr_mode && !WR_DATA[`MODE_DBG_BIT])
      begin
        DEBUG_ACTIVE <= 1'b0;
        entry_open   <= 1'b0;
      end
      else if (wr_special && WR_DATA[`SPC_ENTRY_BIT] && entry_open)
      begin
        DEBUG_ACTIVE <= 1'b1;
        entry_bit    <= 1'b1;
        entry_open   <= 1'b0;
      end
      if ((WR_STB && !wr_special) || (win_cnt == win_lim))
        entry_open <= 1'b0;
    end
  end

  // Watchdog and monitor faults
  assign evt      = {STARTUP_TIMEOUT, INT_TIMEOUT, WD_WINDOW_MISS, WD_OVERFLOW};
  assign fault    = |evt;
  assign suppress = DEBUG_ACTIVE && !LOW_POWER_MODE;

  always @*
  begin
    next_flags = INT_FLAGS;
    if (wr_int)
      next_flags = next_flags & ~WR_DATA[`EVT_W-1:0];
    next_flags = next_flags | evt;
    if (any_rst)
      next_flags = {`EVT_W{1'b0}};
  end

  always @*
  begin
    next_source = RESET_SOURCE;
    if (evt[`EVT_WD_OVF])
      next_source = `RSRC_WD_OVF;
    else if (evt[`EVT_WD_WIN])
      next_source = `RSRC_WD_WIN;
    else if (evt[`EVT_INT_TO])
      next_source = `RSRC_INT_TO;
    else if (evt[`EVT_SU_TO])
      next_source = `RSRC_SU_TO;
  end

  always @(posedge CLK or negedge RST_N)
  begin
    if (!RST_N)
    begin
      INT_FLAGS    <= {`EVT_W{1'b0}};
      RESET_SOURCE <= `RSRC_NONE;
      RESET_REQ    <= 1'b0;
      INT_REQ      <= 1'b0;
    end
    else
    begin
      INT_FLAGS    <= next_flags;
      RESET_SOURCE <= next_source;
      RESET_REQ    <= fault && !suppress;
      INT_REQ      <= |(next_flags & INT_EN_FB);
    end
  end

  assign INT_MON_EN     = !DEBUG_ACTIVE;
  assign WD_INIT_MON_EN = !DEBUG_ACTIVE;
  assign RST_MON_EN     = !DEBUG_ACTIVE;
  assign FAILSAFE_GO    = FAILSAFE_REQ && (!DEBUG_ACTIVE || uv_long);

endmodule // sbc_reset_state

// *** verif/sbc_reset_state_chk.sv ***
module sbc_reset_state_chk (
  input logic        CLK,
  input logic        RST_N,
  input logic        STARTUP_RST,
  input logic        EXT_RST,
  input logic        RESTART_RST,
  input logic        WR_STB,
  input logic [2:0]  WR_SEL,
  input logic [11:0] WR_DATA,
  input logic        LOW_POWER_MODE,
  input logic        MAIN_UV,
  input logic        FAILSAFE_REQ,
  input logic        WD_OVERFLOW,
  input logic [9:0]  SYSCFG_FB,
  input logic [3:0]  INT_EN_FB,
  input logic [3:0]  INT_FLAGS,
  input logic [11:0] GP0_FB,
  input logic        DEBUG_ACTIVE,
  input logic        RESET_REQ,
  input logic [3:0]  RESET_SOURCE,
  input logic        INT_MON_EN,
  input logic        WD_INIT_MON_EN,
  input logic        RST_MON_EN,
  input logic        FAILSAFE_GO
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (!RST_N);
  a_restart_load: assert property (RESTART_RST && !WR_STB |=> SYSCFG_FB[5:4] == 2'h1
    && SYSCFG_FB[9:8] == 2'h0 && INT_FLAGS == 4'h0 && GP0_FB[11])
    else $error("restart reload wrong");
  a_ext_v3off: assert property (EXT_RST && !RESTART_RST && !WR_STB
    |=> SYSCFG_FB[7:6] == 2'h0) else $error("external reset kept third supply");
  a_startup_keep: assert property (STARTUP_RST && !EXT_RST && !RESTART_RST && !WR_STB
    |=> $stable(SYSCFG_FB[7:4]) && $stable(INT_EN_FB)) else $error("start-up lost fields");
  a_uv_float: assert property (MAIN_UV && !WR_STB |=> SYSCFG_FB[9:8] == 2'h0)
    else $error("load switch not floating");
  a_fault_reset: assert property (WD_OVERFLOW && (!DEBUG_ACTIVE || LOW_POWER_MODE)
    |=> RESET_REQ && RESET_SOURCE == 4'h1) else $error("fault gave no reset");
  a_debug_quiet: assert property (WD_OVERFLOW && DEBUG_ACTIVE && !LOW_POWER_MODE
    |=> !RESET_REQ && INT_FLAGS[0]) else $error("debug fault handled wrongly");
  a_monitors_off: assert property (DEBUG_ACTIVE
    |-> !(INT_MON_EN || WD_INIT_MON_EN || RST_MON_EN)) else $error("monitor left on");
  a_failsafe_block: assert property (FAILSAFE_REQ && DEBUG_ACTIVE && !MAIN_UV
    && !$past(MAIN_UV) |-> !FAILSAFE_GO) else $error("fail-safe not blocked");
  a_failsafe_pass: assert property (FAILSAFE_REQ && !DEBUG_ACTIVE |-> FAILSAFE_GO)
    else $error("fail-safe request dropped");
  a_mode_exit: assert property (WR_STB && WR_SEL == 3'h0 && !WR_DATA[0]
    |=> !DEBUG_ACTIVE [*4]) else $error("debug kept after mode write");
  a_gp0_mark: assert property (WR_STB && WR_SEL == 3'h6 |=> GP0_FB[11])
    else $error("identity mark not set");
  c_debug_fault: cover property (DEBUG_ACTIVE && WD_OVERFLOW);
  c_ext_reset: cover property (EXT_RST);
  c_long_uv: cover property (DEBUG_ACTIVE && FAILSAFE_GO);
endmodule // sbc_reset_state_chk

bind sbc_reset_state sbc_reset_state_chk sbc_reset_state_chk_inst (.*);

// *** verif/sbc_host_model.sv ***
module sbc_host_model (
  input  logic        CLK,
  output logic        WR_STB,
  output logic [2:0]  WR_SEL,
  output logic [11:0] WR_DATA
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    WR_STB = 1'b0;
    WR_SEL = 3'h0;
    WR_DATA = 12'h000;
  end
  task automatic wr(input logic [2:0] sel, input logic [11:0] data);
    @(posedge CLK);
    WR_STB <= 1'b1;
    WR_SEL <= sel;
    WR_DATA <= data;
    @(posedge CLK);
    WR_STB <= 1'b0;
    // Released data shows no stale value
    WR_DATA <= ~data;
    #1;
  endtask
  task automatic mode(input logic stay);
    wr(3'h0, {11'h000, stay});
  endtask
  task automatic enter_debug();
    wr(3'h5, 12'h001);
  endtask
endmodule // sbc_host_model

// *** verif/sbc_reset_state_tb.sv ***
module sbc_reset_state_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        CLK, RST_N, STARTUP_RST, EXT_RST, RESTART_RST, RESET_OUT_IN, RESET_OUT_DRIVE;
  logic        TEST_PIN_HIGH, LOW_POWER_MODE, MAIN_UV, FAILSAFE_REQ, GND_SHIFT_LIVE;
  logic        WD_OVERFLOW, WD_WINDOW_MISS, INT_TIMEOUT, STARTUP_TIMEOUT, WR_STB;
  logic [1:0]  LIN_FAIL_LIVE, CAN_MODE_LIVE;
  logic [2:0]  SUPPLY_DIAG_LIVE, SPECIAL_FB, WR_SEL;
  logic [3:0]  CAN_FAIL_LIVE, INT_EN_FB, INT_FLAGS, RESET_SOURCE;
  logic [7:0]  PHY_FB;
  logic [9:0]  SYSCFG_FB;
  logic [11:0] DIAG_WORD, GP0_FB, GP1_FB, WR_DATA;
  logic        DEBUG_ACTIVE, RESET_REQ, INT_REQ, INT_MON_EN, WD_INIT_MON_EN, RST_MON_EN;
  logic        FAILSAFE_GO;
  int          fails, cmp_count, n;
  sbc_reset_state #(.STARTUP_CYC(50), .MAIN_UV_CYC(20)) sbc_reset_state_inst (.*);
  sbc_host_model sbc_host_model_inst (.*);
  initial
  begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end
  task automatic chk(input string what, input logic [11:0] exp, input logic [11:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic conclude();
    if (fails == 0 && cmp_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic power_on(input logic test);
    @(posedge CLK);
    RST_N <= 1'b0;
    TEST_PIN_HIGH <= test;
    repeat (16) @(posedge CLK);
    RST_N <= 1'b1;
    #1;
  endtask
  // Class bits {restart, external, start-up}; fault bits as in the flag word
  task automatic pulse(input logic [2:0] k, input logic [3:0] f);
    @(posedge CLK);
    {RESTART_RST, EXT_RST, STARTUP_RST} <= k;
    {STARTUP_TIMEOUT, INT_TIMEOUT, WD_WINDOW_MISS, WD_OVERFLOW} <= f;
    @(posedge CLK);
    {RESTART_RST, EXT_RST, STARTUP_RST} <= 3'h0;
    {STARTUP_TIMEOUT, INT_TIMEOUT, WD_WINDOW_MISS, WD_OVERFLOW} <= 4'h0;
    #1;
  endtask
  task automatic por_values();
    power_on(1'b0);
    chk("diag", 12'h380, DIAG_WORD);
    chk("syscfg", 12'h014, SYSCFG_FB);
    chk("phy", 12'h042, PHY_FB);
    chk("int_en", 12'h000, INT_EN_FB);
    chk("special", 12'h000, SPECIAL_FB);
    chk("gp0", 12'h2AA, GP0_FB);
    chk("gp1", 12'h000, GP1_FB);
  endtask
  task automatic retain_and_classes();
    sbc_host_model_inst.wr(3'h3, 12'h3FF);
    sbc_host_model_inst.wr(3'h1, 12'h00F);
    sbc_host_model_inst.wr(3'h4, 12'h0BD);
    sbc_host_model_inst.wr(3'h7, 12'hA5C);
    sbc_host_model_inst.wr(3'h5, 12'h006);
    sbc_host_model_inst.wr(3'h6, 12'h123);
    chk("gp0 mark", 12'h923, GP0_FB);
    sbc_host_model_inst.wr(3'h6, 12'h000);
    chk("gp0 rewrite", 12'h800, GP0_FB);
    pulse(3'h1, 4'h0);
    chk("diag live", 12'hD35, DIAG_WORD);
    chk("syscfg su", 12'h3FF, SYSCFG_FB);
    chk("int_en su", 12'h00F, INT_EN_FB);
    chk("phy su", 12'h0BD, PHY_FB);
    chk("gp1 su", 12'hA5C, GP1_FB);
    chk("gp0 su", 12'h800, GP0_FB);
    chk("special su", 12'h006, SPECIAL_FB);
    pulse(3'h2, 4'h0);
    chk("syscfg ext", 12'h03F, SYSCFG_FB);
    @(posedge CLK);
    GND_SHIFT_LIVE <= 1'b0;
    @(posedge CLK);
    #1;
    chk("diag follow", 12'hD34, DIAG_WORD);
    pulse(3'h4, 4'h0);
    chk("syscfg rs", 12'h01F, SYSCFG_FB);
    chk("int_en rs", 12'h00F, INT_EN_FB);
    chk("special rs", 12'h006, SPECIAL_FB);
  endtask
  task automatic faults_and_clear();
    for (int i = 0; i < 4; i++)
    begin
      pulse(3'h0, 4'h1 << i);
      chk("flag", 12'h001 << i, INT_FLAGS);
      chk("source", 12'(i + 1), RESET_SOURCE);
      chk("reset req", 12'h001, RESET_REQ);
      chk("int req", 12'h001, INT_REQ);
      sbc_host_model_inst.wr(3'h2, 12'h00F);
    end
    for (int k = 1; k < 8; k = k * 2)
    begin
      pulse(3'h0, 4'h1);
      pulse(3'(k), 4'h0);
      chk("flags cleared", 12'h000, INT_FLAGS);
    end
    sbc_host_model_inst.wr(3'h3, 12'h3FF);
    pulse(3'h0, 4'h1);
    @(posedge CLK);
    RESET_OUT_IN <= 1'b0;
    repeat (3) @(posedge CLK);
    RESET_OUT_IN <= 1'b1;
    #1;
    chk("pin flags", 12'h000, INT_FLAGS);
    chk("pin syscfg", 12'h03F, SYSCFG_FB);
    pulse(3'h0, 4'h1);
    @(posedge CLK);
    {RESET_OUT_DRIVE, RESET_OUT_IN} <= 2'h2;
    repeat (3) @(posedge CLK);
    {RESET_OUT_DRIVE, RESET_OUT_IN} <= 2'h1;
    #1;
    chk("own drive", 12'h001, INT_FLAGS);
  endtask
  task automatic debug_sw();
    power_on(1'b0);
    sbc_host_model_inst.enter_debug();
    chk("debug on", 12'h001, DEBUG_ACTIVE);
    chk("monitors", 12'h000, {INT_MON_EN, WD_INIT_MON_EN, RST_MON_EN});
    sbc_host_model_inst.wr(3'h1, 12'h001);
    pulse(3'h0, 4'h1);
    chk("dbg req", 12'h000, RESET_REQ);
    chk("dbg flag", 12'h001, INT_FLAGS);
    chk("dbg src", 12'h001, RESET_SOURCE);
    chk("dbg int", 12'h001, INT_REQ);
    @(posedge CLK);
    LOW_POWER_MODE <= 1'b1;
    pulse(3'h0, 4'h1);
    chk("low power req", 12'h001, RESET_REQ);
    @(posedge CLK);
    LOW_POWER_MODE <= 1'b0;
    FAILSAFE_REQ <= 1'b1;
    pulse(3'h4, 4'h0);
    chk("failsafe held", 12'h000, FAILSAFE_GO);
    chk("restart keeps", 12'h003, {SPECIAL_FB[0], DEBUG_ACTIVE});
    chk("gp0 rs", 12'hAAA, GP0_FB);
    @(posedge CLK);
    MAIN_UV <= 1'b1;
    for (n = 0; n < 40 && FAILSAFE_GO !== 1'b1; n++)
    begin
      @(posedge CLK);
      #1;
    end
    if (n == 40)
    begin
      fails++;
      conclude();
    end
    chk("long uv", 12'h014, 12'(n));
    @(posedge CLK);
    MAIN_UV <= 1'b0;
    FAILSAFE_REQ <= 1'b0;
    sbc_host_model_inst.mode(1'b1);
    chk("mode keep", 12'h001, DEBUG_ACTIVE);
    sbc_host_model_inst.mode(1'b0);
    chk("mode leave", 12'h000, DEBUG_ACTIVE);
    sbc_host_model_inst.enter_debug();
    chk("no reentry", 12'h000, DEBUG_ACTIVE);
    @(posedge CLK);
    FAILSAFE_REQ <= 1'b1;
    @(posedge CLK);
    #1;
    chk("failsafe free", 12'h001, FAILSAFE_GO);
    chk("monitors back", 12'h007, {INT_MON_EN, WD_INIT_MON_EN, RST_MON_EN});
    @(posedge CLK);
    FAILSAFE_REQ <= 1'b0;
    #1;
  endtask
  task automatic debug_refused();
    power_on(1'b0);
    sbc_host_model_inst.wr(3'h7, 12'h001);
    sbc_host_model_inst.enter_debug();
    chk("late write", 12'h000, {SPECIAL_FB[0], DEBUG_ACTIVE});
    power_on(1'b0);
    repeat (60) @(posedge CLK);
    sbc_host_model_inst.enter_debug();
    chk("late time", 12'h000, {SPECIAL_FB[0], DEBUG_ACTIVE});
    power_on(1'b1);
    @(posedge CLK);
    #1;
    chk("pin entry", 12'h001, DEBUG_ACTIVE);
  endtask
  initial
  begin
    {RST_N, STARTUP_RST, EXT_RST, RESTART_RST, RESET_OUT_DRIVE} = 5'h00;
    {TEST_PIN_HIGH, LOW_POWER_MODE, MAIN_UV, FAILSAFE_REQ} = 4'h0;
    {STARTUP_TIMEOUT, INT_TIMEOUT, WD_WINDOW_MISS, WD_OVERFLOW} = 4'h0;
    RESET_OUT_IN = 1'b1;
    {CAN_MODE_LIVE, SUPPLY_DIAG_LIVE, LIN_FAIL_LIVE, CAN_FAIL_LIVE, GND_SHIFT_LIVE} = 12'hD35;
    fails = 0;
    cmp_count = 0;
    por_values();
    retain_and_classes();
    faults_and_clear();
    debug_sw();
    debug_refused();
    conclude();
  end
endmodule // sbc_reset_state_tb
